// file: design/twe_slave.sv
// device end: two-wire 256-byte memory slave
`default_nettype none
module twe_slave
   import twe_pkg::*;
#(
   parameter int PROG_CYC = PROG_CYC_DEF
) (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // bus
   twe_if.device bus,
   // strapped select pins
   input wire logic [2:0] device_select_pins,
   // status
   output logic busy
);
   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK, S_WADR, S_WDAT, S_RDAT, S_RACK} st_type;
   logic [7:0] mem_q [4][MEM_WORDS/4]; // four byte lanes, one per page byte
   logic scl_m, sda_m, scl_s, sda_s, scl_p, sda_p; // synchronisers and history
   logic [2:0] pins_m, pins_s; // select pins, two-flop sampled
   st_type st_q, st_d;
   st_type nx_q, nx_d;        // state after the acknowledge bit
   logic [3:0] bit_q, bit_d;
   logic [7:0] sh_q, sh_d;
   logic [7:0] ptr_q, ptr_d;  // address counter
   logic [7:0] pw_d [4];
   logic [7:0] pw_q [4];      // page data held until stop
   logic [3:0] pv_q, pv_d;    // page byte written flags
   logic [5:0] pbase_q, pbase_d;
   logic ack_q, ack_d;        // drive ack low during ninth clock
   logic tx_q, tx_d;          // data bit being sent; a one releases SDA
   logic [31:0] bcnt_q, bcnt_d;
   logic start, stop, rise, fall, match;
   ////////////////////////////////////////////////////////////////
   // two-flop sampling of the bus lines
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         scl_m <= 1'b1;
         sda_m <= 1'b1;
         scl_s <= 1'b1;
         sda_s <= 1'b1;
         scl_p <= 1'b1;
         sda_p <= 1'b1;
         pins_m <= 3'h0;
         pins_s <= 3'h0;
      end else begin
         scl_m <= bus.scl;
         sda_m <= bus.sda;
         scl_s <= scl_m;
         sda_s <= sda_m;
         scl_p <= scl_s;
         sda_p <= sda_s;
         pins_m <= device_select_pins;
         pins_s <= pins_m;
      end
   end
   ////////////////////////////////////////////////////////////////
   // protocol next state
   always_comb begin
      start = scl_s && scl_p && sda_p && !sda_s;
      stop = scl_s && scl_p && !sda_p && sda_s;
      rise = scl_s && !scl_p;
      fall = !scl_s && scl_p;
      // type code and select pins
      // address byte: type code, select bits, then the direction bit
      match = (sh_q[7:4] == DEV_TYPE) && (sh_q[3:1] == pins_s);
      st_d = st_q;
      nx_d = nx_q;
      bit_d = bit_q;
      sh_d = sh_q;
      ptr_d = ptr_q;
      pw_d = pw_q;
      pv_d = pv_q;
      pbase_d = pbase_q;
      ack_d = ack_q;
      tx_d = tx_q;
      bcnt_d = bcnt_q;
      if (bcnt_q != 32'h0) begin
         // programming, bus ignored; follows since no ack is driven
         bcnt_d = bcnt_q - 32'h1;
         st_d = S_IDLE;
         ack_d = 1'b0;
         tx_d = 1'b0;
      end else if (stop) begin
         // data held in the page is programmed at stop
         if (pv_q != 4'h0) begin
            bcnt_d = 32'(PROG_CYC);
         end
         // page flags drop in the same cycle the lanes commit
         pv_d = 4'h0;
         st_d = S_IDLE;
         ack_d = 1'b0;
         tx_d = 1'b0;
      end else if (start) begin
         // bus watched again from every start outside programming
         st_d = S_ADDR;
         bit_d = 4'h0;
         ack_d = 1'b0;
         tx_d = 1'b0;
      end else begin
         unique case (st_q)
            S_IDLE: begin
            end
            S_ADDR, S_WADR, S_WDAT: begin
               if (rise) begin
                  sh_d = {sh_q[6:0], sda_s};
                  bit_d = bit_q + 4'h1;
               end else if (fall && bit_q == 4'h8) begin
                  bit_d = 4'h0;
                  st_d = S_ACK;
                  ack_d = 1'b1;
                  if (st_q == S_ADDR) begin
                     ack_d = match;
                     nx_d = !match ? S_IDLE : (sh_q[0] ? S_RDAT : S_WADR);
                     sh_d = mem_q[ptr_q[1:0]][ptr_q[7:2]];
                  end else if (st_q == S_WADR) begin
                     ptr_d = sh_q;
                     pbase_d = sh_q[7:2];
                     nx_d = S_WDAT;
                  end else begin
                     // ack every data byte; page wrap
                     pw_d[ptr_q[1:0]] = sh_q;
                     pv_d[ptr_q[1:0]] = 1'b1;
                     ptr_d = {pbase_q, ptr_q[1:0] + 2'h1};
                     nx_d = S_WDAT;
                  end
               end
            end
            S_ACK: begin
               // ack held for the ninth clock, released at its fall
               if (fall) begin
                  ack_d = 1'b0;
                  st_d = nx_q;
                  if (nx_q == S_RDAT) begin
                     // first data bit set up while SCL low
                     tx_d = sh_q[7];
                  end
               end
            end
            S_RDAT: begin
               if (rise) begin
                  bit_d = bit_q + 4'h1;
               end else if (fall) begin
                  if (bit_q == 4'h8) begin
                     // release SDA for the master's ack
                     tx_d = 1'b0;
                     bit_d = 4'h0;
                     st_d = S_RACK;
                     // counter to next location, full wrap
                     ptr_d = ptr_q + 8'h1;
                  end else begin
                     sh_d = {sh_q[6:0], 1'b0};
                     tx_d = sh_q[6];
                  end
               end
            end
            S_RACK: begin
               if (rise) begin
                  // ack continues, no ack ends sending
                  st_d = sda_s ? S_IDLE : S_RACK;
                  sh_d = mem_q[ptr_q[1:0]][ptr_q[7:2]];
                  bit_d = sda_s ? 4'h0 : 4'h1;
               end else if (fall && bit_q == 4'h1) begin
                  st_d = S_RDAT;
                  bit_d = 4'h0;
                  tx_d = sh_q[7];
               end
            end
            default: st_d = S_IDLE;
         endcase
      end
   end
   // protocol registers
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= S_IDLE;
         nx_q <= S_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         ptr_q <= 8'h00;
         pw_q <= '{default: 8'h00};
         pv_q <= 4'h0;
         pbase_q <= 6'h00;
         ack_q <= 1'b0;
         tx_q <= 1'b0;
         bcnt_q <= 32'h0;
      end else begin
         st_q <= st_d;
         nx_q <= nx_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         ptr_q <= ptr_d;
         pw_q <= pw_d;
         pv_q <= pv_d;
         pbase_q <= pbase_d;
         ack_q <= ack_d;
         tx_q <= tx_d;
         bcnt_q <= bcnt_d;
      end
   end
   ////////////////////////////////////////////////////////////////
   // memory lanes, page committed at stop; no reset on the cells
   // one lane per process, so no two processes write the same lane
   for (genvar i = 0; i < 4; i++) begin : g_page
      always_ff @(posedge mclk) begin
         if (stop && bcnt_q == 32'h0 && pv_q[i]) begin
            mem_q[i][pbase_q] <= pw_q[i];
         end
      end
   end
   // open drain, only pulls low; a data one releases the line
   assign bus.s_sda_o = 1'b0;
   assign bus.s_sda_oe = ack_q || (st_q == S_RDAT && !tx_q);
   // busy for PROG_CYC cycles after a write stop
   assign busy = (bcnt_q != 32'h0);
endmodule
`default_nettype wire

// file: design/twe_pkg.sv
// shared constants and types for the two-wire memory slave and its master
`default_nettype none
package twe_pkg;
   // device type code compared with the upper four address bits (value arbitrary)
   localparam logic [3:0] DEV_TYPE = 4'hA;
   // memory geometry
   localparam int MEM_WORDS = 256;
   localparam int PAGE_BITS = 2;
   // link clock: master divides mclk; quarter period in mclk cycles
   localparam int SCL_HALF_NS = 24;
   localparam int MCLK_NS = 4;
   localparam int SCL_HALF_CYC = (SCL_HALF_NS + MCLK_NS - 1) / MCLK_NS;
   // default programming busy time in mclk cycles
   localparam int PROG_CYC_DEF = 64;
   // master command kinds
   typedef enum logic [1:0] {CMD_WRITE, CMD_READ, CMD_ADDR} cmd_type;
endpackage
`default_nettype wire

// file: design/twe_if.sv
// two-wire bus carrier with open-drain resolution
`default_nettype none
interface twe_if;
   // master side
   logic scl;
   logic m_sda_o;
   logic m_sda_oe;
   // device side
   logic s_sda_o;
   logic s_sda_oe;
   // resolved wired-and data line with pull-up
   logic sda;
   assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));
   modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
   modport device (input scl, output s_sda_o, output s_sda_oe, input sda);
endinterface
`default_nettype wire

// file: design/twe_buf2.sv
// two-entry valid/ready buffer
`default_nettype none
module twe_buf2 #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem_q [2];
   logic [WIDTH-1:0] mem_d [2];
   logic rd_q, rd_d, wr_q, wr_d; // one-bit pointers
   logic [1:0] cnt_q, cnt_d;     // occupancy
   logic push, pop;
   ////////////////////////////////////////////////////////////////
   // next state: full and empty from the count
   always_comb begin
      in_ready = (cnt_q != 2'h2);
      out_valid = (cnt_q != 2'h0);
      out_data = mem_q[rd_q];
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      mem_d = mem_q;
      if (push) begin
         mem_d[wr_q] = in_data;
      end
      wr_d = wr_q ^ push;
      rd_d = rd_q ^ pop;
      cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
   end
   // registers
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         mem_q[0] <= '0;
         mem_q[1] <= '0;
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         mem_q <= mem_d;
         rd_q <= rd_d;
         wr_q <= wr_d;
         cnt_q <= cnt_d;
      end
   end
endmodule
`default_nettype wire

// file: design/twe_master.sv
// master end: issues byte writes, reads and address polls on the two-wire bus
`default_nettype none
module twe_master
   import twe_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // bus
   twe_if.master bus,
   // command
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire cmd_type cmd_kind,
   input wire logic [2:0] cmd_sel,
   input wire logic [7:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   // answer, through the two-entry buffer
   output logic rsp_valid,
   input wire logic rsp_ready,
   output logic [8:0] rsp_data
);
   typedef enum logic [2:0] {M_IDLE, M_START, M_BITS, M_STOP, M_WAIT} mst_type;
   mst_type st_q, st_d;
   logic [3:0] div_q, div_d;
   logic tick;
   logic [5:0] bit_q, bit_d;   // bit index within the frame
   logic [26:0] sh_q, sh_d;    // three bytes each followed by an ack slot
   logic [5:0] len_q, len_d;
   logic [1:0] ph_q, ph_d;     // quarter phase of an SCL period
   logic scl_q, scl_d, sdo_q, sdo_d, ack_q, ack_d;
   logic [7:0] rx_q, rx_d;
   logic rd_q, rd_d;
   logic bval, bready;
   logic sda_m, sda_s;
   // data line sample
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sda_m <= 1'b1;
         sda_s <= 1'b1;
      end else begin
         sda_m <= bus.sda;
         sda_s <= sda_m;
      end
   end
   ////////////////////////////////////////////////////////////////
   // divider and sequencer; frames of 9-bit slots, SDA changes at low phase
   always_comb begin
      tick = (div_q == 4'(SCL_HALF_CYC - 1));
      div_d = tick ? 4'h0 : div_q + 4'h1;
      st_d = st_q;
      bit_d = bit_q;
      sh_d = sh_q;
      len_d = len_q;
      ph_d = ph_q;
      scl_d = scl_q;
      sdo_d = sdo_q;
      ack_d = ack_q;
      rx_d = rx_q;
      rd_d = rd_q;
      bval = 1'b0;
      cmd_ready = (st_q == M_IDLE) && bready;
      unique case (st_q)
         M_IDLE: begin
            if (cmd_valid && bready) begin
               rd_d = (cmd_kind == CMD_READ);
               sh_d = {DEV_TYPE, cmd_sel, rd_d, 1'b1, cmd_addr, 1'b1, cmd_wdata, 1'b1};
               len_d = (cmd_kind == CMD_WRITE) ? 6'd27 : 6'd18;
               ack_d = 1'b1;
               st_d = M_START;
               ph_d = 2'h0;
            end
         end
         M_START: if (tick) begin
            sdo_d = 1'b0;
            st_d = M_BITS;
            bit_d = 6'h0;
            ph_d = 2'h0;
         end
         M_BITS: if (tick) begin
            ph_d = ph_q + 2'h1;
            if (ph_q == 2'h0) begin
               scl_d = 1'b0;
            end else if (ph_q == 2'h1) begin
               sdo_d = sh_q[26] || (rd_q && bit_q > 6'd8);
            end else if (ph_q == 2'h2) begin
               scl_d = 1'b1;
            end else begin
               // only slave answers count; our own read no-ack does not
               if (bit_q == 6'd8 || (!rd_q && (bit_q == 6'd17 || bit_q == 6'd26))) begin
                  ack_d = ack_q && !sda_s;
               end
               if (rd_q && bit_q > 6'd8 && bit_q < 6'd17) begin
                  rx_d = {rx_q[6:0], sda_s};
               end
               sh_d = {sh_q[25:0], 1'b1};
               bit_d = bit_q + 6'h1;
               // stop after last slot or unanswered address
               if (bit_q + 6'h1 == len_q || (bit_q == 6'd8 && sda_s)) begin
                  st_d = M_STOP;
               end
            end
         end
         M_STOP: if (tick) begin
            ph_d = ph_q + 2'h1;
            if (ph_q == 2'h0) begin
               scl_d = 1'b0;
            end else if (ph_q == 2'h1) begin
               sdo_d = 1'b0;
            end else if (ph_q == 2'h2) begin
               scl_d = 1'b1;
            end else begin
               sdo_d = 1'b1;
               st_d = M_WAIT;
            end
         end
         M_WAIT: if (tick) begin
            bval = 1'b1;
            st_d = M_IDLE;
         end
         default: st_d = M_IDLE;
      endcase
   end
   // registers
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= M_IDLE;
         div_q <= 4'h0;
         bit_q <= 6'h0;
         sh_q <= '1;
         len_q <= 6'h0;
         ph_q <= 2'h0;
         scl_q <= 1'b1;
         sdo_q <= 1'b1;
         ack_q <= 1'b0;
         rx_q <= 8'h00;
         rd_q <= 1'b0;
      end else begin
         st_q <= st_d;
         div_q <= div_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         len_q <= len_d;
         ph_q <= ph_d;
         scl_q <= scl_d;
         sdo_q <= sdo_d;
         ack_q <= ack_d;
         rx_q <= rx_d;
         rd_q <= rd_d;
      end
   end
   // pins: SCL pushed, SDA open drain
   assign bus.scl = scl_q;
   assign bus.m_sda_o = 1'b0;
   assign bus.m_sda_oe = !sdo_q;
   // answer buffer: ack flag and read byte
   twe_buf2 #(.WIDTH(9)) u_buf (
      .mclk(mclk),
      .arst_n(arst_n),
      .in_valid(bval),
      .in_ready(bready),
      .in_data({ack_q, rx_q}),
      .out_valid(rsp_valid),
      .out_ready(rsp_ready),
      .out_data(rsp_data)
   );
endmodule
`default_nettype wire

// file: dv/twe_checker.sv
// concurrent checks on the two-wire link between master and memory slave
`default_nettype none
module twe_checker
   import twe_pkg::*;
#(
   parameter int PROG_CYC = PROG_CYC_DEF
) (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // link signals
   input wire logic scl,
   input wire logic m_sda_o,
   input wire logic m_sda_oe,
   input wire logic s_sda_o,
   input wire logic s_sda_oe,
   input wire logic sda,
   // slave status
   input wire logic busy
);
   timeunit 1ns;
   timeprecision 1ps;
   // longest pull-low by the slave: ack then eight zero bits, plus slack
   localparam int OE_MAX = 9 * 4 * SCL_HALF_CYC + 12;
   ////////////////////////////////////////////////////////////////////////
   logic seen_q, seen_d; // a start has been seen since reset
   logic scl_q, sda_q; // last samples, for start detection
   logic [15:0] oe_cnt_q, oe_cnt_d; // cycles the slave has pulled low
   logic [15:0] busy_cnt_q, busy_cnt_d; // cycles of programming so far
   // next values of the helper state
   always_comb begin
      seen_d = seen_q || (scl && scl_q && sda_q && !sda);
      oe_cnt_d = s_sda_oe ? oe_cnt_q + 16'h0001 : 16'h0000;
      busy_cnt_d = busy ? busy_cnt_q + 16'h0001 : 16'h0000;
   end
   // registers only; idle bus levels at reset avoid a false start
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         seen_q <= 1'b0;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         oe_cnt_q <= 16'h0000;
         busy_cnt_q <= 16'h0000;
      end else begin
         seen_q <= seen_d;
         scl_q <= scl;
         sda_q <= sda;
         oe_cnt_q <= oe_cnt_d;
         busy_cnt_q <= busy_cnt_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   // both ends only ever pull low
   property p_open_drain;
      !(s_sda_oe && s_sda_o) && !(m_sda_oe && m_sda_o);
   endproperty
   property p_quiet_before_start;
      !seen_q |-> !s_sda_oe;
   endproperty
   property p_change_scl_low;
      $changed(s_sda_oe) |-> !scl;
   endproperty
   property p_busy_silent;
      busy |-> !s_sda_oe;
   endproperty
   property p_busy_at_stop;
      $rose(busy) |-> scl && sda;
   endproperty
   property p_busy_hold;
      $rose(busy) |=> busy [*8];
   endproperty
   property p_busy_bound;
      int'(busy_cnt_q) <= PROG_CYC + 2;
   endproperty
   property p_oe_bound;
      int'(oe_cnt_q) <= OE_MAX;
   endproperty
   property p_stop_release;
      $rose(sda) && scl |=> !s_sda_oe [*4];
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("sda driven high");
   a_quiet_before_start: assert property (p_quiet_before_start)
      else $error("slave drove sda before any start");
   a_change_scl_low: assert property (p_change_scl_low)
      else $error("slave sda changed while scl high");
   a_busy_silent: assert property (p_busy_silent) else $error("slave answered while busy");
   a_busy_at_stop: assert property (p_busy_at_stop) else $error("busy began off a stop");
   a_busy_hold: assert property (p_busy_hold) else $error("busy period cut short");
   a_busy_bound: assert property (p_busy_bound) else $error("busy period overran");
   a_oe_bound: assert property (p_oe_bound) else $error("slave held sda too long");
   a_stop_release: assert property (p_stop_release) else $error("slave drove after stop");
   // main scenarios reached
   c_busy: cover property ($rose(busy));
   c_ack: cover property ($rose(s_sda_oe) && !scl);
   c_stop: cover property ($rose(sda) && scl);
endmodule
`default_nettype wire

// file: dv/tb.sv
// self-checking bench: master and memory slave joined over the two-wire link
`default_nettype none
module tb
   import twe_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   // programming time raised above the default of 64 cycles so polls land while busy
   localparam int PROG = 1000;
   localparam int LIMIT = 90000;
   // clock, reset and command side
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic cmd_valid = 1'b0;
   logic cmd_ready;
   cmd_type cmd_kind = CMD_WRITE;
   logic [2:0] cmd_sel = 3'h0;
   logic [7:0] cmd_addr = 8'h00;
   logic [7:0] cmd_wdata = 8'h00;
   logic rsp_valid;
   logic rsp_ready = 1'b1;
   logic [8:0] rsp_data;
   logic [2:0] pins = 3'h0; // strapped select level
   logic busy;
   // random state and reference model
   logic [31:0] seed = 32'h3A70;
   logic [31:0] stall = 32'h3A70;
   int miscompares = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [7:0] mem_model [int]; // cells never written stay absent
   int ptr = 0; // model of the address counter
   logic [8:0] got;
   ////////////////////////////////////////////////////////////////////////
   twe_if link_if ();
   twe_slave #(.PROG_CYC(PROG)) twe_slave_inst (.mclk(mclk), .arst_n(arst_n),
      .bus(link_if.device), .device_select_pins(pins), .busy(busy));
   twe_master twe_master_inst (.mclk(mclk), .arst_n(arst_n), .bus(link_if.master),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
      .cmd_sel(cmd_sel), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data));
   twe_checker #(.PROG_CYC(PROG)) twe_checker_inst (.mclk(mclk), .arst_n(arst_n),
      .scl(link_if.scl), .m_sda_o(link_if.m_sda_o), .m_sda_oe(link_if.m_sda_oe),
      .s_sda_o(link_if.s_sda_o), .s_sda_oe(link_if.s_sda_oe), .sda(link_if.sda),
      .busy(busy));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic final_report();
      if (miscompares == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one command, held until taken, then its answer at the accepting edge
   task automatic run(input cmd_type k, input logic [2:0] s, input logic [7:0] a,
                      input logic [7:0] d);
      @(negedge mclk);
      cmd_valid = 1'b1;
      cmd_kind = k;
      cmd_sel = s;
      cmd_addr = a;
      cmd_wdata = d;
      do @(posedge mclk); while (cmd_ready !== 1'b1);
      @(negedge mclk);
      cmd_valid = 1'b0;
      do @(posedge mclk); while ((rsp_valid & rsp_ready) !== 1'b1);
      got = rsp_data;
   endtask
   // pins move only between frames, off the sampling edge
   task automatic new_pins();
      @(negedge mclk);
      seed = lfsr(seed);
      pins = seed[2:0];
   endtask
   task automatic write_b(input logic [7:0] a, input logic [7:0] d);
      run(CMD_WRITE, pins, a, d);
      check("write ack", {8'h00, got[8]}, 9'h001);
      mem_model[a] = d;
      ptr = int'({a[7:2], 2'(a[1:0] + 2'h1)}); // low two bits wrap in the page
   endtask
   task automatic set_ptr(input logic [7:0] a);
      run(CMD_ADDR, pins, a, 8'h00);
      check("address ack", {8'h00, got[8]}, 9'h001);
      ptr = a;
   endtask
   task automatic read_cur();
      run(CMD_READ, pins, 8'h00, 8'h00);
      if (mem_model.exists(ptr))
         check("read data", got, {1'b1, mem_model[ptr]});
      else
         check("read ack", {8'h00, got[8]}, 9'h001);
      ptr = (ptr + 1) % MEM_WORDS;
   endtask
   task automatic settle();
      repeat (PROG + 200) @(posedge mclk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   always #2 mclk = ~mclk;
   // receiver stalls at random; the buffer must hold the answer
   always @(negedge mclk) begin
      stall = lfsr(stall);
      rsp_ready = stall[0] | stall[1];
   end
   // hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         miscompares++;
         final_report();
      end
   end
   initial begin
      repeat (16) @(posedge mclk);
      @(negedge mclk);
      arst_n = 1'b1;
      // four writes across the top of memory: 254, 255, 0, 1
      for (int i = 0; i < 4; i++) begin
         new_pins();
         write_b(8'(254 + i), seed[15:8]);
         settle();
      end
      set_ptr(8'hFE);
      repeat (4) read_cur();
      // write to 255 leaves counter at 252, the page start
      write_b(8'hFC, 8'hA5);
      settle();
      write_b(8'hFF, 8'h5A);
      settle();
      read_cur();
      for (int i = 0; i < 6; i++) begin
         new_pins();
         write_b(seed[23:16], seed[31:24]);
         settle();
         set_ptr(seed[23:16]);
         read_cur();
      end
      // polls during programming go unanswered and change nothing
      write_b(8'h40, 8'hC3);
      run(CMD_WRITE, pins, 8'h40, 8'h3C);
      check("poll ack", {8'h00, got[8]}, 9'h000);
      run(CMD_READ, pins, 8'h00, 8'h00);
      check("busy read ack", {8'h00, got[8]}, 9'h000);
      settle();
      set_ptr(8'h40);
      read_cur();
      // each select bit must match its pin
      set_ptr(8'hFE);
      for (int b = 0; b < 3; b++) begin
         run(CMD_ADDR, pins ^ 3'(1 << b), 8'h00, 8'h00);
         check("select ack", {8'h00, got[8]}, 9'h000);
      end
      read_cur();
      final_report();
   end
endmodule
`default_nettype wire
